/* pkg/gsl_pkg.sv */
// constants and types shared by the status lamp controller
package gsl_pkg;
    // =====================================================
    // clock and timing
    localparam int CLK_HZ        = 10_000_000;
    localparam int CYC_PER_MS    = CLK_HZ / 1000;
    localparam int GAP_MS        = 2000;             // dark gap of a coded blink
    localparam int PULSE_MS      = 500;              // pulse and pause of a coded blink
    localparam int FLASH_HALF_MS = 500;              // half period of plain flashing
    localparam int STALL_MS      = 10000;            // longest normal yellow start phase
    localparam int PULSE_CYC     = PULSE_MS * CYC_PER_MS;
    localparam int FLASH_CYC     = FLASH_HALF_MS * CYC_PER_MS;
    localparam int GAP_STEPS     = GAP_MS / PULSE_MS;
    localparam int STALL_STEPS   = STALL_MS / PULSE_MS;
    // =====================================================
    // widths and reset values
    localparam int DIV_W         = 24;
    localparam int SEQ_W         = 3;
    localparam int STALL_W       = 5;
    localparam logic LAMP_RST    = 1'b0;
    // =====================================================
    // platform lamp states, gray along start -> run
    typedef enum logic [1:0] {
        GSL_PL_START = 2'b00,
        GSL_PL_RUN   = 2'b01,
        GSL_PL_BOOT  = 2'b11,
        GSL_PL_STALL = 2'b10
    } gsl_plat_t;
endpackage

/* pkg/gsl_pat_if.sv */
// pattern timing signals shared by divider, sequencer and lamp logic
`timescale 1ns/1ps
interface gsl_pat_if;
    logic step_tick;   // one pulse per coded-blink step
    logic flash_tick;  // one pulse per flash half period
    logic flash;       // plain flash phase
    logic code_one;    // single pulse code
    logic code_two;    // double pulse code
    modport tick (output step_tick, output flash_tick);
    modport seq  (input step_tick, input flash_tick, output flash, output code_one,
                  output code_two);
    modport lamp (input step_tick, input flash_tick, input flash, input code_one,
                  input code_two);
endinterface

/* verilog/gsl_tick.sv */
// free-running dividers making the step and flash enables
`timescale 1ns/1ps
module gsl_tick #(
    parameter int STEP_CYC  = gsl_pkg::PULSE_CYC,
    parameter int FLASH_CYC = gsl_pkg::FLASH_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    gsl_pat_if.tick  pat
);
    localparam int LIM [2] = '{STEP_CYC, FLASH_CYC};

    // =====================================================
    // one divider per enable
    for (genvar g = 0; g < 2; g++) begin : gen_div
        logic [gsl_pkg::DIV_W-1:0] cnt;
        logic [gsl_pkg::DIV_W-1:0] next_cnt;
        logic                      pulse;
        logic                      next_pulse;
        logic                      wrap;

        // wrap at the limit and emit one enable cycle
        always_comb begin
            wrap       = (cnt == gsl_pkg::DIV_W'(LIM[g] - 1));
            next_cnt   = wrap ? '0 : cnt + 1'b1;
            next_pulse = wrap;
        end

        always_ff @(posedge ref_clk) begin
            if (rst) begin
                cnt   <= '0;
                pulse <= 1'b0;
            end else begin
                cnt   <= next_cnt;
                pulse <= next_pulse;
            end
        end
    end

    assign pat.step_tick  = gen_div[0].pulse;
    assign pat.flash_tick = gen_div[1].pulse;
endmodule

/* verilog/gsl_blink.sv */
// coded blink sequencer and plain flash phase
`timescale 1ns/1ps
module gsl_blink (
    input wire logic ref_clk,
    input wire logic rst,
    gsl_pat_if.seq   pat
);
    localparam logic [gsl_pkg::SEQ_W-1:0] GAP  = gsl_pkg::SEQ_W'(gsl_pkg::GAP_STEPS);
    localparam logic [gsl_pkg::SEQ_W-1:0] END1 = GAP;
    localparam logic [gsl_pkg::SEQ_W-1:0] END2 = GAP + 3'h2;

    logic [gsl_pkg::SEQ_W-1:0] c1;
    logic [gsl_pkg::SEQ_W-1:0] c2;
    logic                      flash;
    logic [gsl_pkg::SEQ_W-1:0] next_c1;
    logic [gsl_pkg::SEQ_W-1:0] next_c2;
    logic                      next_flash;

    // =====================================================
    // step counters: gap steps dark, then the pulse steps
    always_comb begin
        next_c1    = c1;
        next_c2    = c2;
        next_flash = flash;
        if (pat.step_tick) begin
            next_c1 = (c1 == END1) ? '0 : c1 + 1'b1;
            next_c2 = (c2 == END2) ? '0 : c2 + 1'b1;
        end
        if (pat.flash_tick) begin
            next_flash = ~flash;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            c1    <= '0;
            c2    <= '0;
            flash <= 1'b0;
        end else begin
            c1    <= next_c1;
            c2    <= next_c2;
            flash <= next_flash;
        end
    end

    assign pat.flash    = flash;
    assign pat.code_one = (c1 == GAP);
    assign pat.code_two = (c2 == GAP) || (c2 == END2);
endmodule

/* verilog/gsl_top.sv */
// status lamp controller top: platform, gateway, scanner and port lamps
//
// How it works
// - platform lamp steady green once OS runs
// - steady yellow only while starting; long yellow flags stall
// - bootloader error flashes platform lamp yellow/green
// - platform lamp dark on hardware failure
// - both ports exchanging and running: gateway green
// - first port idle: green 2s off, one pulse
// - second port idle: green 2s off, two pulses
// - first port config bad: red, one pulse
// - second port config bad: red, two pulses
// - initialization error: gateway lamp steady red
// - module health steady green when operating
// - module health flashes green when unconfigured
// - major fault: module health steady red
// - minor fault: module health flashes red
// - self-test: both health lamps alternate green/red
// - connection established: network health steady green
// - address but no connection: flash green
// - duplicate address: network health steady red
// - connection timeout flashes red until restored
// - no address: network health lamp dark
// - connection lamp follows Ethernet link
// - traffic lamp flashes on frame activity
`timescale 1ns/1ps
module gsl_top #(
    parameter int STEP_CYC  = gsl_pkg::PULSE_CYC,
    parameter int FLASH_CYC = gsl_pkg::FLASH_CYC
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic os_running,
    input  wire logic boot_error,
    input  wire logic hw_fault,
    input  wire logic gw_init,
    input  wire logic gw_running,
    input  wire logic init_error,
    input  wire logic first_protocol_port_xchg,
    input  wire logic second_protocol_port_xchg,
    input  wire logic first_protocol_port_cfg_bad,
    input  wire logic second_protocol_port_cfg_bad,
    input  wire logic scanner_loaded,
    input  wire logic self_test,
    input  wire logic configured,
    input  wire logic major_fault,
    input  wire logic minor_fault,
    input  wire logic ip_obtained,
    input  wire logic conn_established,
    input  wire logic duplicate_ip,
    input  wire logic conn_timeout,
    input  wire logic conn_restored,
    input  wire logic eth_link,
    input  wire logic eth_frame,
    output logic      platform_lamp_grn,
    output logic      platform_lamp_yel,
    output logic      platform_stall,
    output logic      gateway_function_lamp_grn,
    output logic      gateway_function_lamp_red,
    output logic      module_health_lamp_grn,
    output logic      module_health_lamp_red,
    output logic      network_health_lamp_grn,
    output logic      network_health_lamp_red,
    output logic      connection_lamp,
    output logic      traffic_lamp
);
    gsl_pat_if pat ();

    gsl_tick #(
        .STEP_CYC  (STEP_CYC),
        .FLASH_CYC (FLASH_CYC)
    ) u_tick (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pat     (pat.tick)
    );

    gsl_blink u_blink (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pat     (pat.seq)
    );

    // =====================================================
    // state and next values
    gsl_pkg::gsl_plat_t              pl_state;
    gsl_pkg::gsl_plat_t              next_pl_state;
    logic [gsl_pkg::STALL_W-1:0]     stall_cnt;
    logic [gsl_pkg::STALL_W-1:0]     next_stall_cnt;
    logic                            tmo;
    logic                            next_tmo;
    logic                            act;
    logic                            next_act;
    logic                            next_pl_grn;
    logic                            next_pl_yel;
    logic                            next_gw_grn;
    logic                            next_gw_red;
    logic                            next_mh_grn;
    logic                            next_mh_red;
    logic                            next_nh_grn;
    logic                            next_nh_red;
    logic                            next_traffic;

    // =====================================================
    // platform lamp sequence
    always_comb begin
        next_pl_state  = pl_state;
        next_stall_cnt = stall_cnt;
        case (pl_state)
            gsl_pkg::GSL_PL_START: begin
                if (pat.step_tick) begin
                    next_stall_cnt = stall_cnt + 1'b1;
                end
                if (stall_cnt == gsl_pkg::STALL_W'(gsl_pkg::STALL_STEPS)) begin
                    next_pl_state = gsl_pkg::GSL_PL_STALL;
                end
            end
            gsl_pkg::GSL_PL_RUN, gsl_pkg::GSL_PL_BOOT: begin
                next_stall_cnt = '0;
            end
            gsl_pkg::GSL_PL_STALL: begin
                next_stall_cnt = stall_cnt;
            end
            default: begin
                next_pl_state = gsl_pkg::GSL_PL_START;
            end
        endcase
        if (boot_error) begin
            next_pl_state = gsl_pkg::GSL_PL_BOOT;
        end else if (os_running) begin
            next_pl_state = gsl_pkg::GSL_PL_RUN;
        end else if (pl_state != gsl_pkg::GSL_PL_STALL &&
                     pl_state != gsl_pkg::GSL_PL_START) begin
            next_pl_state  = gsl_pkg::GSL_PL_START;
            next_stall_cnt = '0;
        end
    end

    // platform lamp colours, dark on hardware failure
    always_comb begin
        next_pl_grn = 1'b0;
        next_pl_yel = 1'b0;
        if (hw_fault) begin
            next_pl_grn = 1'b0;
            next_pl_yel = 1'b0;
        end else if (boot_error) begin
            next_pl_grn = pat.flash;
            next_pl_yel = ~pat.flash;
        end else if (os_running) begin
            next_pl_grn = 1'b1;
        end else begin
            next_pl_yel = 1'b1;
        end
    end

    // =====================================================
    // gateway function lamp, errors ahead of exchange codes
    always_comb begin
        next_gw_grn = 1'b0;
        next_gw_red = 1'b0;
        if (init_error) begin
            next_gw_red = 1'b1;
        end else if (!gw_init) begin
            next_gw_red = 1'b0;
        end else if (first_protocol_port_cfg_bad) begin
            next_gw_red = pat.code_one;
        end else if (second_protocol_port_cfg_bad) begin
            next_gw_red = pat.code_two;
        end else if (!first_protocol_port_xchg) begin
            next_gw_grn = pat.code_one;
        end else if (!second_protocol_port_xchg) begin
            next_gw_grn = pat.code_two;
        end else if (gw_running) begin
            next_gw_grn = 1'b1;
        end
    end

    // =====================================================
    // module health lamp
    always_comb begin
        next_mh_grn = 1'b0;
        next_mh_red = 1'b0;
        if (!scanner_loaded) begin
            next_mh_grn = 1'b0;
        end else if (self_test) begin
            next_mh_grn = pat.flash;
            next_mh_red = ~pat.flash;
        end else if (major_fault) begin
            next_mh_red = 1'b1;
        end else if (minor_fault) begin
            next_mh_red = pat.flash;
        end else if (!configured) begin
            next_mh_grn = pat.flash;
        end else begin
            next_mh_grn = 1'b1;
        end
    end

    // =====================================================
    // network health lamp and sticky timeout
    always_comb begin
        next_tmo    = conn_timeout | (tmo & ~conn_restored);
        next_nh_grn = 1'b0;
        next_nh_red = 1'b0;
        if (!scanner_loaded) begin
            next_nh_grn = 1'b0;
        end else if (self_test) begin
            next_nh_grn = pat.flash;
            next_nh_red = ~pat.flash;
        end else if (duplicate_ip) begin
            next_nh_red = 1'b1;
        end else if (tmo) begin
            next_nh_red = pat.flash;
        end else if (!ip_obtained) begin
            next_nh_red = 1'b0;
        end else if (conn_established) begin
            next_nh_grn = 1'b1;
        end else begin
            next_nh_grn = pat.flash;
        end
    end

    // =====================================================
    // traffic lamp: frames keep it toggling at flash rate
    always_comb begin
        next_act     = eth_frame | (act & ~pat.flash_tick);
        next_traffic = traffic_lamp;
        if (pat.flash_tick) begin
            next_traffic = act ? ~traffic_lamp : 1'b0;
        end
    end

    // =====================================================
    // registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pl_state                  <= gsl_pkg::GSL_PL_START;
            stall_cnt                 <= '0;
            tmo                       <= 1'b0;
            act                       <= 1'b0;
            platform_lamp_grn         <= gsl_pkg::LAMP_RST;
            platform_lamp_yel         <= gsl_pkg::LAMP_RST;
            platform_stall            <= 1'b0;
            gateway_function_lamp_grn <= gsl_pkg::LAMP_RST;
            gateway_function_lamp_red <= gsl_pkg::LAMP_RST;
            module_health_lamp_grn    <= gsl_pkg::LAMP_RST;
            module_health_lamp_red    <= gsl_pkg::LAMP_RST;
            network_health_lamp_grn   <= gsl_pkg::LAMP_RST;
            network_health_lamp_red   <= gsl_pkg::LAMP_RST;
            connection_lamp           <= gsl_pkg::LAMP_RST;
            traffic_lamp              <= gsl_pkg::LAMP_RST;
        end else begin
            pl_state                  <= next_pl_state;
            stall_cnt                 <= next_stall_cnt;
            tmo                       <= next_tmo;
            act                       <= next_act;
            platform_lamp_grn         <= next_pl_grn;
            platform_lamp_yel         <= next_pl_yel;
            platform_stall            <= (next_pl_state == gsl_pkg::GSL_PL_STALL);
            gateway_function_lamp_grn <= next_gw_grn;
            gateway_function_lamp_red <= next_gw_red;
            module_health_lamp_grn    <= next_mh_grn;
            module_health_lamp_red    <= next_mh_red;
            network_health_lamp_grn   <= next_nh_grn;
            network_health_lamp_red   <= next_nh_red;
            connection_lamp           <= eth_link;
            traffic_lamp              <= next_traffic;
        end
    end

    // =====================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_run_green;
        os_running && !boot_error && !hw_fault |=> platform_lamp_grn && !platform_lamp_yel;
    endproperty
    a_run_green: assert property (p_run_green) else $error("platform not green");

    property p_stall_yel;
        platform_stall |-> platform_lamp_yel || $past(hw_fault);
    endproperty
    a_stall_yel: assert property (p_stall_yel) else $error("stall without yellow");

    property p_boot_alt;
        boot_error && !hw_fault |=> platform_lamp_yel == !platform_lamp_grn
            && platform_lamp_grn == $past(pat.flash);
    endproperty
    a_boot_alt: assert property (p_boot_alt) else $error("boot flash wrong");

    property p_dark;
        hw_fault |=> !platform_lamp_grn && !platform_lamp_yel;
    endproperty
    a_dark: assert property (p_dark) else $error("platform lamp lit on fault");

    property p_gw_green;
        !init_error && gw_init && gw_running && first_protocol_port_xchg
            && second_protocol_port_xchg && !first_protocol_port_cfg_bad
            && !second_protocol_port_cfg_bad |=> gateway_function_lamp_grn
            && !gateway_function_lamp_red;
    endproperty
    a_gw_green: assert property (p_gw_green) else $error("gateway not green");

    property p_gw_code1;
        !init_error && gw_init && !first_protocol_port_cfg_bad
            && !second_protocol_port_cfg_bad && !first_protocol_port_xchg
            |=> gateway_function_lamp_grn == $past(pat.code_one);
    endproperty
    a_gw_code1: assert property (p_gw_code1) else $error("first idle code wrong");

    property p_gw_red1;
        !init_error && gw_init && first_protocol_port_cfg_bad
            |=> gateway_function_lamp_red == $past(pat.code_one)
            && !gateway_function_lamp_grn;
    endproperty
    a_gw_red1: assert property (p_gw_red1) else $error("first cfg code wrong");

    property p_gw_red2;
        !init_error && gw_init && !first_protocol_port_cfg_bad && second_protocol_port_cfg_bad
            |=> gateway_function_lamp_red == $past(pat.code_two);
    endproperty
    a_gw_red2: assert property (p_gw_red2) else $error("second cfg code wrong");

    property p_gw_init_err;
        init_error |=> gateway_function_lamp_red && !gateway_function_lamp_grn;
    endproperty
    a_gw_init_err: assert property (p_gw_init_err) else $error("init error not red");

    property p_major;
        scanner_loaded && !self_test && major_fault |=> module_health_lamp_red
            && !module_health_lamp_grn;
    endproperty
    a_major: assert property (p_major) else $error("major fault not red");

    property p_self_test;
        scanner_loaded && self_test |=> module_health_lamp_grn != module_health_lamp_red
            && network_health_lamp_grn == module_health_lamp_grn;
    endproperty
    a_self_test: assert property (p_self_test) else $error("self-test pattern wrong");

    property p_dup_ip;
        scanner_loaded && !self_test && duplicate_ip |=> network_health_lamp_red;
    endproperty
    a_dup_ip: assert property (p_dup_ip) else $error("duplicate ip not red");

    property p_tmo_hold;
        conn_timeout ##1 (!conn_restored && !rst) [*2] |=> tmo;
    endproperty
    a_tmo_hold: assert property (p_tmo_hold) else $error("timeout dropped early");

    property p_no_ip;
        scanner_loaded && !self_test && !duplicate_ip && !tmo && !ip_obtained
            |=> !network_health_lamp_grn && !network_health_lamp_red;
    endproperty
    a_no_ip: assert property (p_no_ip) else $error("lamp lit without address");

    property p_link;
        eth_link |=> connection_lamp;
    endproperty
    a_link: assert property (p_link) else $error("link lamp dark");

    property p_traffic;
        $rose(traffic_lamp) |-> $past(pat.flash_tick) && $past(act);
    endproperty
    a_traffic: assert property (p_traffic) else $error("traffic lamp off cadence");
endmodule

/* testbench/gsl_led_model.sv */
// lamp model: integrates how many cycles each front-panel lamp is lit
`timescale 1ns/1ps
module gsl_led_model (
    input  wire logic        ref_clk,
    input  wire logic        clr,
    input  wire logic [9:0]  lamps,
    output logic      [15:0] lit [10]
);
    // =====================================================
    // light integration, cleared at the start of each window
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < 10; i++) begin
            lit[i] <= clr ? 16'h0000 : lit[i] + 16'(lamps[i]);
        end
    end
endmodule

/* testbench/gsl_top_tb_top.sv */
// self-checking bench of the status lamp controller
`timescale 1ns/1ps
module gsl_top_tb_top;
    typedef struct packed {
        logic os, boot, hw, gwi, gwr, ierr, xa, xb, b1, b2;
        logic sc, stt, cfg, maj, mnr, ip, ce, dup, link, trf;
    } gsl_tb_in_t;
    localparam int WIN = 420;            // common multiple of every pattern period
    localparam int S   = WIN;
    localparam int F   = WIN / 2;
    localparam int C1  = WIN / 5;        // one lit step in five
    localparam int C2  = WIN * 2 / 7;    // two lit steps in seven
    logic        ref_clk   = 1'b0;
    logic        rst       = 1'b1;
    gsl_tb_in_t  cur       = '0;
    logic        tmo       = 1'b0;
    logic        rstd      = 1'b0;
    logic        frm       = 1'b0;
    logic        clr       = 1'b0;
    logic [9:0]  lamps;
    logic        stall;
    logic [15:0] lit [10];
    int          n_fail    = 0;
    int          cmp_count = 0;
    int          n_test    = 0;
    integer      seed      = 80;

    // =====================================================
    // clock, frame traffic and watchdog
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) frm <= cur.trf & ~frm;
    initial begin
        #(100 * 60000);
        n_fail++;
        report_and_stop();
    end

    // =====================================================
    // design and lamp model
    gsl_top #(.STEP_CYC(4), .FLASH_CYC(3)) u_gsl_top (
        .ref_clk(ref_clk), .rst(rst), .os_running(cur.os), .boot_error(cur.boot),
        .hw_fault(cur.hw), .gw_init(cur.gwi), .gw_running(cur.gwr), .init_error(cur.ierr),
        .first_protocol_port_xchg(cur.xa), .second_protocol_port_xchg(cur.xb),
        .first_protocol_port_cfg_bad(cur.b1), .second_protocol_port_cfg_bad(cur.b2),
        .scanner_loaded(cur.sc), .self_test(cur.stt), .configured(cur.cfg),
        .major_fault(cur.maj), .minor_fault(cur.mnr), .ip_obtained(cur.ip),
        .conn_established(cur.ce), .duplicate_ip(cur.dup), .conn_timeout(tmo),
        .conn_restored(rstd), .eth_link(cur.link), .eth_frame(frm),
        .platform_lamp_grn(lamps[9]), .platform_lamp_yel(lamps[8]), .platform_stall(stall),
        .gateway_function_lamp_grn(lamps[7]), .gateway_function_lamp_red(lamps[6]),
        .module_health_lamp_grn(lamps[5]), .module_health_lamp_red(lamps[4]),
        .network_health_lamp_grn(lamps[3]), .network_health_lamp_red(lamps[2]),
        .connection_lamp(lamps[1]), .traffic_lamp(lamps[0])
    );
    gsl_led_model u_gsl_led_model (.ref_clk(ref_clk), .clr(clr), .lamps(lamps), .lit(lit));

    // =====================================================
    // expected lit counts per lamp over one window
    function automatic void expect_all(input gsl_tb_in_t s, input logic flag, output int e[10]);
        e = '{default: 0};
        if (s.hw) e[9] = 0;
        else if (s.boot) begin e[9] = F; e[8] = F; end
        else if (s.os) e[9] = S;
        else e[8] = S;
        if (s.ierr) e[6] = S;
        else if (!s.gwi) e[6] = 0;
        else if (s.b1) e[6] = C1;
        else if (s.b2) e[6] = C2;
        else if (!s.xa) e[7] = C1;
        else if (!s.xb) e[7] = C2;
        else if (s.gwr) e[7] = S;
        if (!s.sc) e[5] = 0;
        else if (s.stt) begin e[5] = F; e[4] = F; e[3] = F; e[2] = F; end
        else begin
            if (s.maj) e[4] = S;
            else if (s.mnr) e[4] = F;
            else e[5] = s.cfg ? S : F;
            if (s.dup) e[2] = S;
            else if (flag) e[2] = F;
            else if (s.ip) e[3] = s.ce ? S : F;
        end
        e[1] = s.link ? S : 0;
        e[0] = s.trf ? F : 0;
    endfunction

    // =====================================================
    // comparison, verdict and stimulus tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t lamp value %0d, want %0d", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic run_win(input gsl_tb_in_t s, input logic flag);
        int e[10];
        expect_all(s, flag, e);
        @(posedge ref_clk);
        cur <= s;
        repeat (12) @(posedge ref_clk);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        repeat (WIN) @(posedge ref_clk);
        #1;
        for (int i = 8; i < 10; i++) check(lit[i], 16'(e[i]));
        if (!s.hw) check(16'(stall), 16'(!s.os && !s.boot));
        for (int i = 6; i < 8; i++) check(lit[i], 16'(e[i]));
        for (int i = 4; i < 6; i++) check(lit[i], 16'(e[i]));
        for (int i = 2; i < 4; i++) check(lit[i], 16'(e[i]));
        check(lit[1], 16'(e[1]));
        check(lit[0], 16'(e[0]));
        n_test++;
        $display("test %0d done", n_test);
    endtask

    task automatic pulse(input logic set, input logic clear);
        @(posedge ref_clk);
        tmo  <= set;
        rstd <= clear;
        @(posedge ref_clk);
        tmo  <= 1'b0;
        rstd <= 1'b0;
    endtask

    // =====================================================
    // main sequence: random conditions, then timeout flag corners
    initial begin
        gsl_tb_in_t s;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 24; i++) begin
            s = gsl_tb_in_t'(20'($random(seed)));
            s.ierr = s.ierr & s.b2;
            s.hw   = s.hw & s.ip;
            s.stt  = s.stt & s.maj;
            s.sc   = s.sc | s.gwr;
            s.gwi  = s.gwi | s.xb;
            if (i == 0) s = '{os: 1'b1, gwi: 1'b1, gwr: 1'b1, xa: 1'b1, xb: 1'b1, sc: 1'b1,
                              cfg: 1'b1, ip: 1'b1, ce: 1'b1, link: 1'b1, default: 1'b0};
            run_win(s, 1'b0);
        end
        s = '{os: 1'b1, sc: 1'b1, cfg: 1'b1, ip: 1'b1, ce: 1'b1, default: 1'b0};
        pulse(1'b1, 1'b0);
        run_win(s, 1'b1);
        s.dup = 1'b1;
        run_win(s, 1'b1);
        s.dup = 1'b0;
        pulse(1'b1, 1'b1);
        run_win(s, 1'b1);
        pulse(1'b0, 1'b1);
        run_win(s, 1'b0);
        pulse(1'b1, 1'b0);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        run_win(s, 1'b0);
        report_and_stop();
    end
endmodule
